// *** sadc_ctrl.sv ***
// Control logic of the 10-bit successive approximation converter
// Assumes an analog core with a comparator output and sync inputs
`timescale 1ns/100ps
`include "sadc_params.svh"
module sadc_ctrl (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RESET,
  input  wire sadc_pkg::sadc_avs_req_t AVS_REQ,
  output logic [31:0]                 AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  input  wire logic                   ASYNC_CLK,
  input  wire logic                   ALT_CLK,
  input  wire logic                   HW_TRIG,
  input  wire logic                   COMP_IN,
  output sadc_pkg::sadc_ana_t         ANA,
  output logic [7:0]                  PIN_EN,
  output logic                        DONE_REQ
);
  import sadc_pkg::*;

  logic        ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0]  sc1_ff, nxt_sc1;
  logic [2:0]  sc2_ff, nxt_sc2;
  logic [9:0]  res_ff, nxt_res;
  logic [9:0]  cmp_ff, nxt_cmp;
  logic [7:0]  cfg_ff, nxt_cfg;
  logic [3:0]  pin1_ff, nxt_pin1;
  logic [3:0]  pin2_ff, nxt_pin2;
  logic        done_ff, nxt_done;
  sadc_state_t st_ff, nxt_st;
  sadc_src_t   src_ff, nxt_src;
  logic [9:0]  sar_ff, nxt_sar;
  logic [9:0]  bit_ff, nxt_bit;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [3:0]  clk_sel_ff, nxt_clk_sel;
  logic [2:0]  div_ff, nxt_div;
  logic        half_ff, async_q_ff, alt_q_ff;
  logic        req, fin, wr_sc1, rd_res;
  logic        src_tick, tick, conv_end, cmp_true, start;
  logic [9:0]  val, val_j;
  logic [2:0]  div_max;

  function automatic sadc_src_t decode(input logic [4:0] ch);
    unique case (ch)
      5'h00, 5'h01, 5'h02, 5'h03: decode = sadc_src_t'({2'b00, ch[1:0]});
      5'h08, 5'h09, 5'h0a, 5'h0b: decode = sadc_src_t'({2'b01, ch[1:0]});
      5'h16, 5'h17, 5'h18, 5'h19, 5'h1c: decode = SADC_SRC_RSVD;
      5'h1a: decode = SADC_SRC_TEMP;
      5'h1b: decode = SADC_SRC_BGAP;
      5'h1d: decode = SADC_SRC_HIGH_REFERENCE_VOLTAGE;
      5'h1f: decode = SADC_SRC_NONE;
      default: decode = SADC_SRC_LOW_REFERENCE_VOLTAGE;
    endcase
  endfunction

  // Bus slave: one wait cycle, then the answer
  assign req = AVS_REQ.read | AVS_REQ.write;
  assign AVS_WAITREQUEST = req & ~ack_ff;
  assign fin = req & ack_ff;
  assign wr_sc1 = fin & AVS_REQ.write & (AVS_REQ.address == `SADC_OFS_SC1);
  assign rd_res = fin & AVS_REQ.read & (AVS_REQ.address == `SADC_OFS_RES);
  assign AVS_READDATA = rdata_ff;
  assign PIN_EN = {pin2_ff, pin1_ff};
  assign DONE_REQ = done_ff & sc1_ff[`SADC_SC1_IEN];

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_sc1 = sc1_ff;
    nxt_sc2 = sc2_ff;
    nxt_cmp = cmp_ff;
    nxt_cfg = cfg_ff;
    nxt_pin1 = pin1_ff;
    nxt_pin2 = pin2_ff;
    if (req & ~ack_ff) begin
      unique case (AVS_REQ.address)
        `SADC_OFS_SC1:  nxt_rdata = {24'h0, done_ff, sc1_ff[6:0]};
        `SADC_OFS_SC2:  nxt_rdata = {24'h0, st_ff != SADC_IDLE, sc2_ff, 4'h0};
        `SADC_OFS_RES:  nxt_rdata = {22'h0, res_ff};
        `SADC_OFS_CMP:  nxt_rdata = {22'h0, cmp_ff};
        `SADC_OFS_CFG:  nxt_rdata = {24'h0, cfg_ff};
        `SADC_OFS_PIN1: nxt_rdata = {28'h0, pin1_ff};
        `SADC_OFS_PIN2: nxt_rdata = {28'h0, pin2_ff};
        default:        nxt_rdata = 32'h0;
      endcase
    end
    if (fin & AVS_REQ.write) begin
      unique case (AVS_REQ.address)
        `SADC_OFS_SC1:  nxt_sc1 = {1'b0, AVS_REQ.writedata[6:0]};
        `SADC_OFS_SC2:  nxt_sc2 = AVS_REQ.writedata[6:4];
        `SADC_OFS_CMP:  nxt_cmp = AVS_REQ.writedata[9:0];
        `SADC_OFS_CFG:  nxt_cfg = AVS_REQ.writedata[7:0];
        `SADC_OFS_PIN1: nxt_pin1 = AVS_REQ.writedata[3:0];
        `SADC_OFS_PIN2: nxt_pin2 = AVS_REQ.writedata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      sc1_ff <= `SADC_SC1_RST;
      sc2_ff <= 3'h0;
      cmp_ff <= 10'h000;
      cfg_ff <= `SADC_CFG_RST;
      pin1_ff <= 4'h0;
      pin2_ff <= 4'h0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      sc1_ff <= nxt_sc1;
      sc2_ff <= nxt_sc2;
      cmp_ff <= nxt_cmp;
      cfg_ff <= nxt_cfg;
      pin1_ff <= nxt_pin1;
      pin2_ff <= nxt_pin2;
    end
  end

  // Conversion clock: source edge, then divider
  // Divider ratio taken from the copy latched while idle
  assign div_max = 3'((4'h1 << clk_sel_ff[3:2]) - 4'h1);
  always_comb begin
    unique case (clk_sel_ff[1:0])
      2'b00: src_tick = 1'b1;
      2'b01: src_tick = half_ff;
      2'b10: src_tick = ASYNC_CLK & ~async_q_ff;
      2'b11: src_tick = ALT_CLK & ~alt_q_ff;
    endcase
    tick = src_tick & (div_ff == div_max);
    nxt_div = src_tick ? ((div_ff == div_max) ? 3'h0 : div_ff + 3'h1) : div_ff;
    nxt_clk_sel = clk_sel_ff;
    if (st_ff == SADC_IDLE) begin
      nxt_clk_sel = {cfg_ff[6:5], cfg_ff[1:0]};
      nxt_div = 3'h0;
    end
  end

  // Successive approximation sequence
  assign val = COMP_IN ? sar_ff : sar_ff & ~bit_ff;
  assign val_j = cfg_ff[`SADC_CFG_MODE10] ? val : {2'b00, val[9:2]};
  assign cmp_true = sc2_ff[0] ? (val_j >= cmp_ff) : (val_j < cmp_ff);
  assign conv_end = (st_ff == SADC_CONV) & tick &
                    (bit_ff == (cfg_ff[`SADC_CFG_MODE10] ? `SADC_LSB10 : `SADC_LSB8));
  assign start = (st_ff == SADC_IDLE) & sc2_ff[2] & HW_TRIG &
                 (sc1_ff[4:0] != `SADC_CHAN_OFF);

  always_comb begin
    nxt_st = st_ff;
    nxt_src = src_ff;
    nxt_sar = sar_ff;
    nxt_bit = bit_ff;
    nxt_cnt = cnt_ff;
    nxt_res = res_ff;
    nxt_done = done_ff;
    if (wr_sc1 | rd_res) begin
      nxt_done = 1'b0;
    end
    unique case (st_ff)
      SADC_IDLE: begin
        if (start) begin
          nxt_st = SADC_SAMPLE;
        end
      end
      SADC_SAMPLE: begin
        if (tick) begin
          nxt_cnt = cnt_ff - 5'h1;
          if (cnt_ff == 5'h1) begin
            nxt_st = SADC_CONV;
            nxt_sar = `SADC_MSB;
            nxt_bit = `SADC_MSB;
          end
        end
      end
      SADC_CONV: begin
        if (tick) begin
          nxt_sar = val | (bit_ff >> 1);
          nxt_bit = bit_ff >> 1;
        end
        if (conv_end) begin
          if (~sc2_ff[1] | cmp_true) begin
            nxt_res = val_j;
            nxt_done = 1'b1;
          end
          nxt_st = sc1_ff[`SADC_SC1_CONT] ? SADC_SAMPLE : SADC_IDLE;
        end
      end
      default: nxt_st = SADC_IDLE;
    endcase
    if (nxt_st == SADC_SAMPLE && st_ff != SADC_SAMPLE) begin
      nxt_cnt = cfg_ff[`SADC_CFG_LSMP] ? `SADC_SMP_LONG : `SADC_SMP_SHORT;
      nxt_src = decode(sc1_ff[4:0]);
    end
    if (wr_sc1) begin
      nxt_src = decode(AVS_REQ.writedata[4:0]);
      nxt_cnt = cfg_ff[`SADC_CFG_LSMP] ? `SADC_SMP_LONG : `SADC_SMP_SHORT;
      if (AVS_REQ.writedata[4:0] == `SADC_CHAN_OFF || sc2_ff[2]) begin
        nxt_st = SADC_IDLE;
      end else begin
        nxt_st = SADC_SAMPLE;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_ff <= SADC_IDLE;
      src_ff <= SADC_SRC_NONE;
      sar_ff <= 10'h000;
      bit_ff <= 10'h000;
      cnt_ff <= 5'h00;
      res_ff <= 10'h000;
      done_ff <= 1'b0;
      clk_sel_ff <= 4'h0;
      div_ff <= 3'h0;
      half_ff <= 1'b0;
      async_q_ff <= 1'b0;
      alt_q_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      src_ff <= nxt_src;
      sar_ff <= nxt_sar;
      bit_ff <= nxt_bit;
      cnt_ff <= nxt_cnt;
      res_ff <= nxt_res;
      done_ff <= nxt_done;
      clk_sel_ff <= nxt_clk_sel;
      div_ff <= nxt_div;
      half_ff <= ~half_ff;
      async_q_ff <= ASYNC_CLK;
      alt_q_ff <= ALT_CLK;
    end
  end

  // Power down outside a conversion
  // One driver for the whole carrier
  assign ANA = '{power:     st_ff != SADC_IDLE,
                 low_power: cfg_ff[`SADC_CFG_LPWR],
                 sample:    st_ff == SADC_SAMPLE,
                 src:       src_ff,
                 trial:     sar_ff};

  // Step counter for checking the sequence length
  logic [3:0] steps_ff;
  sadc_src_t  wr_dec;

  // Channel decode of the word being written, for the restart check
  assign wr_dec = decode(AVS_REQ.writedata[4:0]);
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      steps_ff <= 4'h0;
    end else if (st_ff != SADC_CONV) begin
      steps_ff <= 4'h0;
    end else if (tick) begin
      steps_ff <= steps_ff + 4'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  AST_ABORT_OFF: assert property (wr_sc1 && AVS_REQ.writedata[4:0] == 5'h1f |=> st_ff == SADC_IDLE)
    else $error("Off write did not stop converter");
  AST_RESTART: assert property (wr_sc1 && AVS_REQ.writedata[4:0] != 5'h1f && !sc2_ff[2]
                                |=> st_ff == SADC_SAMPLE && src_ff == $past(wr_dec))
    else $error("Control write did not restart");
  AST_CLEAR: assert property (rd_res && !conv_end |=> !done_ff)
    else $error("Result read did not clear flag");
  AST_OFF_IDLE: assert property (sc1_ff[4:0] == 5'h1f && !$past(wr_sc1) |-> st_ff == SADC_IDLE)
    else $error("Converter runs with off code");
  AST_STEPS: assert property (conv_end |-> steps_ff == (cfg_ff[3] ? 4'd9 : 4'd7))
    else $error("Wrong step count");
  AST_LOW_REFERENCE_VOLTAGE: assert property (st_ff != SADC_IDLE && sc1_ff[4:2] == 3'b001 |-> ANA.src == SADC_SRC_LOW_REFERENCE_VOLTAGE)
    else $error("Unimplemented code not on low reference");
  AST_TEMP: assert property (st_ff != SADC_IDLE && sc1_ff[4:0] == 5'h1a |-> ANA.src == SADC_SRC_TEMP)
    else $error("Temperature code misrouted");
  AST_CLK_HOLD: assert property (st_ff != SADC_IDLE && $past(st_ff) != SADC_IDLE |-> $stable(clk_sel_ff))
    else $error("Clock source changed during conversion");
  AST_DONE: assert property (conv_end && !sc2_ff[1] |=> done_ff && res_ff == $past(val_j))
    else $error("Completion not flagged");
  AST_HWT: assert property (start && !wr_sc1 |=> st_ff == SADC_SAMPLE)
    else $error("Trigger did not start conversion");
  AST_SINGLE: assert property (conv_end && !sc1_ff[5] && !wr_sc1 |=> st_ff == SADC_IDLE)
    else $error("Single conversion did not return idle");
  AST_CONT: assert property (conv_end && sc1_ff[5] && !wr_sc1 |=> st_ff == SADC_SAMPLE)
    else $error("Continuous conversion did not restart");
  AST_CMP_FALSE: assert property (conv_end && sc2_ff[1] && !cmp_true && !wr_sc1 && !rd_res |=> done_ff == $past(done_ff))
    else $error("False compare changed the flag");
  AST_FMT8: assert property (conv_end && !cfg_ff[3] |-> val_j[9:8] == 2'b00)
    else $error("Short result not right-justified");
  AST_WAIT_ONE: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Bus wait longer than one cycle");
  AST_PIN_HOLD: assert property (!(fin && AVS_REQ.write) |=> $stable(PIN_EN))
    else $error("Pin enables changed without a write");

  COV_SINGLE: cover property (conv_end && !sc1_ff[5]);
  COV_CONT: cover property (conv_end && sc1_ff[5] ##1 st_ff == SADC_SAMPLE);
  COV_CMP: cover property (conv_end && sc2_ff[1] && cmp_true);
  COV_HWT: cover property (start);
  COV_ABORT: cover property (wr_sc1 && st_ff != SADC_IDLE);
endmodule

// *** sadc_params.svh ***
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit Avalon-MM slave, byte addresses, one register per word
// Notes on behaviour
// - Five-bit channel field decodes all input codes
// - Ten real inputs: eight pins, temperature sensor, bandgap
// - Unimplemented codes feed the low reference
// - Reserved codes give an undefined result
// - Each pin channel has one enable bit
// - One code routes the temperature sensor
// - Four conversion clock sources are selectable
// - Selected source passes through the divider
// - Alternate clock usable in wait mode
// - Trigger counter overflow starts conversion only when idle
// - Exactly two pin enable registers exist
// - One result bit per step, ten steps (eight in 8-bit mode)
// - Right-justified result, 10-bit or 8-bit
// - Single or continuous; single returns idle
// - Compare less-than or greater-or-equal, flags
// - Completed conversion sets done flag when compare is off or true
// - Sample time and speed/power configurable
// - Control write aborts, restarts unless off or hardware-triggered
// - Done flag cleared by write or read
// - All-ones code turns converter off
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_OFS_SC1     5'h00
`define SADC_OFS_SC2     5'h04
`define SADC_OFS_RES     5'h08
`define SADC_OFS_CMP     5'h0c
`define SADC_OFS_CFG     5'h10
`define SADC_OFS_PIN1    5'h14
`define SADC_OFS_PIN2    5'h18
`define SADC_SC1_DONE    7
`define SADC_SC1_IEN     6
`define SADC_SC1_CONT    5
`define SADC_SC2_ACT     7
`define SADC_SC2_HWT     6
`define SADC_SC2_CMPEN   5
`define SADC_SC2_GTE     4
`define SADC_CFG_LPWR    7
`define SADC_CFG_LSMP    4
`define SADC_CFG_MODE10  3
`define SADC_CHAN_OFF    5'h1f
`define SADC_SC1_RST     8'h1f
`define SADC_CFG_RST     8'h00
`define SADC_SMP_SHORT   5'h04
`define SADC_SMP_LONG    5'h18
`define SADC_MSB         10'h200
`define SADC_LSB10       10'h001
`define SADC_LSB8        10'h004
`endif

// *** sadc_pkg.sv ***
// Types shared by the converter control block
// Assumes sadc_params.svh supplies the numbers
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10
  } sadc_state_t;

  typedef enum logic [3:0] {
    SADC_SRC_PIN0  = 4'h0,
    SADC_SRC_PIN1  = 4'h1,
    SADC_SRC_PIN2  = 4'h2,
    SADC_SRC_PIN3  = 4'h3,
    SADC_SRC_PIN8  = 4'h4,
    SADC_SRC_PIN9  = 4'h5,
    SADC_SRC_PIN10 = 4'h6,
    SADC_SRC_PIN11 = 4'h7,
    SADC_SRC_TEMP  = 4'h8,
    SADC_SRC_BGAP  = 4'h9,
    SADC_SRC_HIGH_REFERENCE_VOLTAGE = 4'ha,
    SADC_SRC_LOW_REFERENCE_VOLTAGE = 4'hb,
    SADC_SRC_RSVD  = 4'hc,
    SADC_SRC_NONE  = 4'hf
  } sadc_src_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } sadc_avs_req_t;

  typedef struct packed {
    logic        power;
    logic        low_power;
    logic        sample;
    sadc_src_t   src;
    logic [9:0]  trial;
  } sadc_ana_t;
endpackage

// *** sadc_core_model.sv ***
// Behavioural analog core: comparator against the selected input level
// Assumes the control block drives trial codes and source select on ANA
`timescale 1ns/100ps
module sadc_core_model (
  input  wire logic                clk,
  input  wire sadc_pkg::sadc_ana_t ana,
  input  wire logic [9:0]          vin,
  output logic                     comp
);
  import sadc_pkg::*;
  logic [9:0] lvl;
  logic       junk = 1'b0;
  always_comb begin
    case (ana.src)
      SADC_SRC_HIGH_REFERENCE_VOLTAGE: lvl = 10'h3ff;
      SADC_SRC_LOW_REFERENCE_VOLTAGE: lvl = 10'h000;
      default:        lvl = vin;
    endcase
  end
  // Unpowered comparator output is meaningless
  always @(posedge clk) junk <= ~junk;
  assign comp = ana.power ? (lvl >= ana.trial) : junk;
endmodule

// *** tb_sar_adc_channel_clock_control.sv ***
// Self-checking bench of the converter control block
// Assumes sadc_core_model answers the comparator input
`timescale 1ns/100ps
`include "sadc_params.svh"
module tb_sar_adc_channel_clock_control;
  import sadc_pkg::*;
  logic          clk = 0, reset = 1, async_clk = 0, alt_clk = 0, alt_en = 0, hw_trig = 0, comp, waitreq, done_req;
  sadc_avs_req_t req = '0;
  sadc_ana_t     ana;
  sadc_src_t     src_seen;
  logic [31:0]   rdata, rd;
  logic [7:0]    pin_en, p1, p2;
  logic [9:0]    vin = 0;
  int            n_mismatch = 0, n_compared = 0, seed = 32'hafc1, n, c, k, g;
  logic [7:0]    cfgs [6] = '{8'h00, 8'h18, 8'h28, 8'h09, 8'h0a, 8'h0b};
  int            lo [6] = '{12, 34, 27, 27, 27, 27};
  int            hi [6] = '{12, 34, 29, 29, 29, 29};

  always #12.5 clk = ~clk;
  always @(posedge clk) async_clk <= ~async_clk;
  always @(posedge clk) alt_clk <= alt_en & ~alt_clk;

  sadc_ctrl i_dut (.SYS_CLK(clk), .RESET(reset), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .ASYNC_CLK(async_clk), .ALT_CLK(alt_clk), .HW_TRIG(hw_trig),
    .COMP_IN(comp), .ANA(ana), .PIN_EN(pin_en), .DONE_REQ(done_req));
  sadc_core_model i_core (.clk(clk), .ana(ana), .vin(vin), .comp(comp));

  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    for (i = 0; i < 20; i++) begin
      #1;
      if (waitreq === 1'b0) break;
      @(posedge clk);
    end
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end else begin
      @(posedge clk);
      rd = rdata;
      req <= '0;
      #1;
    end
  endtask

  // Counts cycles with the converter powered
  task automatic cnt(input int lim);
    int i;
    n = 0;
    for (i = 0; i < lim; i++) begin
      #1;
      if (ana.power === 1'b1) begin
        if (n == 0) src_seen = ana.src;
        n++;
      end else if (n > 0) break;
      @(posedge clk);
    end
  endtask

  function automatic sadc_src_t exp_src(input logic [4:0] ch);
    case (ch) inside
      [0:3]:            return sadc_src_t'({2'b00, ch[1:0]});
      [8:11]:           return sadc_src_t'({2'b01, ch[1:0]});
      26:               return SADC_SRC_TEMP;
      27:               return SADC_SRC_BGAP;
      29:               return SADC_SRC_HIGH_REFERENCE_VOLTAGE;
      31:               return SADC_SRC_NONE;
      [22:25], 28:      return SADC_SRC_RSVD;
      default:          return SADC_SRC_LOW_REFERENCE_VOLTAGE;
    endcase
  endfunction

  function automatic logic [9:0] exp_lvl(input sadc_src_t s);
    if (s == SADC_SRC_HIGH_REFERENCE_VOLTAGE) return 10'h3ff;
    if (s == SADC_SRC_LOW_REFERENCE_VOLTAGE) return 10'h000;
    return vin;
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    bus(0, `SADC_OFS_SC1, 0);
    chk("sc1_reset", rd, 32'h1f);
    chk("pin_reset", pin_en, 0);
    bus(0, 5'h1c, 0);
    chk("unmapped", rd, 0);
    for (k = 0; k < 4; k++) begin
      p1 = $random(seed);
      p2 = $random(seed);
      bus(1, `SADC_OFS_PIN1, p1);
      bus(1, `SADC_OFS_PIN2, p2);
      chk("pin_en", pin_en, {p2[3:0], p1[3:0]});
    end
    bus(1, `SADC_OFS_CFG, 32'h88);
    chk("low_power_on", ana.low_power, 1);
    bus(1, `SADC_OFS_CFG, 32'h08);
    chk("low_power_off", ana.low_power, 0);
    for (c = 0; c < 32; c++) begin
      vin = $random(seed);
      bus(1, `SADC_OFS_SC1, c);
      cnt(c == 31 ? 8 : 60);
      chk("conv_len", n, c == 31 ? 0 : 14);
      if (c != 31) begin
        chk("src", src_seen, exp_src(c));
        bus(0, `SADC_OFS_SC1, 0);
        chk("done", rd[7], 1);
        bus(0, `SADC_OFS_RES, 0);
        if (exp_src(c) != SADC_SRC_RSVD) chk("result", rd, exp_lvl(exp_src(c)));
        bus(0, `SADC_OFS_SC1, 0);
        chk("done_clr", rd[7], 0);
      end
    end
    for (k = 0; k < 6; k++) begin
      if (k == 5) begin
        bus(1, `SADC_OFS_CFG, cfgs[k]);
        bus(1, `SADC_OFS_SC1, 0);
        cnt(40);
        chk("alt_still", n, 40);
        bus(1, `SADC_OFS_SC1, 32'h1f);
        cnt(8);
        chk("abort", n, 0);
        alt_en = 1'b1;
      end
      vin = $random(seed);
      bus(1, `SADC_OFS_CFG, cfgs[k]);
      bus(1, `SADC_OFS_SC1, 0);
      cnt(100);
      chk("clk_len", n >= lo[k] && n <= hi[k], 1);
      bus(0, `SADC_OFS_RES, 0);
      chk("fmt", rd, cfgs[k][3] ? vin : vin[9:2]);
    end
    bus(1, `SADC_OFS_CFG, 32'h08);
    bus(1, `SADC_OFS_SC1, 32'h20);
    n = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (ana.sample === 1'b1) n++;
    end
    chk("continuous", n > 8, 1);
    bus(1, `SADC_OFS_SC1, 32'h1f);
    cnt(20);
    chk("cont_stop", n, 0);
    bus(1, `SADC_OFS_CMP, 32'h155);
    bus(0, `SADC_OFS_CMP, 0);
    chk("cmp_value", rd, 32'h155);
    for (g = 0; g < 2; g++) begin
      bus(1, `SADC_OFS_SC2, 32'h20 | (g << 4));
      for (k = 0; k < 2; k++) begin
        vin = 10'h154 + k;
        bus(1, `SADC_OFS_SC1, 32'h40);
        cnt(60);
        repeat (2) @(posedge clk);
        #1;
        chk("compare", done_req, g ? (k == 1) : (k == 0));
      end
    end
    bus(1, `SADC_OFS_SC2, 32'h40);
    bus(1, `SADC_OFS_SC1, 32'h40);
    cnt(10);
    chk("hwt_write", n, 0);
    @(posedge clk);
    hw_trig <= 1'b1;
    @(posedge clk);
    hw_trig <= 1'b0;
    cnt(60);
    chk("hwt_len", n, 14);
    #30;
    chk("hwt_done", done_req, 1);
    print_verdict();
  end
endmodule
